// [hdl/cit_pkg.sv]
// Purpose: shared constants for the instruction sequencer and flag unit
// Assumes: one core clock, program bytes valid by the last clock of a machine cycle
// Notes: opcodes are the standard 8-bit instruction set encodings
// Functional notes
// RULE_01 - machine cycle is exactly four clocks
// RULE_02 - at most one fetch per machine cycle
// RULE_03 - most instructions: one machine cycle per byte
// RULE_04 - jumps and calls add one address cycle
// RULE_05 - results and flags match the standard core
// RULE_06 - adds and subtract set flags; mul/div clear carry
// RULE_07 - listed carry operations leave overflow, half carry
// RULE_08 - cycle counts: 1, 2, 3 jumps, 4 compare
package cit_pkg;
   localparam int unsigned MC_CLKS    = 4;
   localparam logic [1:0]  PH_FETCH   = 2'h0;
   localparam logic [1:0]  PH_LAST    = 2'h3;
   localparam logic [15:0] PC_RESET   = 16'h0000;
   localparam logic [7:0]  BYTE_RESET = 8'h00;
   localparam logic [2:0]  CYC_SHORT  = 3'h1;
   localparam logic [2:0]  CYC_TWO    = 3'h2;
   localparam logic [2:0]  CYC_THREE  = 3'h3;
   localparam logic [2:0]  CYC_CMP_JUMP = 3'h4;
   localparam logic [2:0]  CYC_MULDIV = 3'h5;
   localparam logic [7:0]  OP_MUL     = 8'ha4;
   localparam logic [7:0]  OP_DIV     = 8'h84;
   localparam logic [7:0]  OP_DEC_ADJ = 8'hd4;
   localparam logic [7:0]  OP_RRC     = 8'h13;
   localparam logic [7:0]  OP_RLC     = 8'h33;
   localparam logic [7:0]  OP_SETC    = 8'hd3;
   localparam logic [7:0]  OP_CLRC    = 8'hc3;
   localparam logic [7:0]  OP_CPLC    = 8'hb3;
   localparam logic [7:0]  OP_ANLC    = 8'h82;
   localparam logic [7:0]  OP_ANLCN   = 8'hb0;
   localparam logic [7:0]  OP_ORLC    = 8'h72;
   localparam logic [7:0]  OP_ORLCN   = 8'ha0;
   localparam logic [7:0]  OP_MOVC    = 8'ha2;
   localparam logic [7:0]  OP_ANLDA   = 8'h52;
   localparam logic [7:0]  OP_ANLDI   = 8'h53;
   localparam logic [7:0]  OP_CLRA    = 8'he4;
   localparam logic [7:0]  OP_CPLA    = 8'hf4;
   localparam logic [7:0]  OP_DECA    = 8'h14;
   localparam logic [3:0]  HI_ADD     = 4'h2;
   localparam logic [3:0]  HI_ADD_CARRY  = 4'h3;
   localparam logic [3:0]  HI_ANL        = 4'h5;
   localparam logic [3:0]  HI_SUB_BORROW = 4'h9;
   localparam logic [3:0]  HI_CMP_JUMP   = 4'hb;
   localparam logic [4:0]  LO_ABS_JUMP   = 5'h01;
   localparam logic [4:0]  LO_ABS_CALL   = 5'h11;
   localparam logic [7:0]  BCD_LO_ADJ = 8'h06;
   localparam logic [8:0]  BCD_HI_ADJ = 9'h060;
   localparam logic [3:0]  BCD_MAX    = 4'h9;

   // sequencer state: fetching bytes or running the extra cycles of jumps and mul/div
   typedef enum logic [0:0] {
      ST_BYTE = 1'b0,
      ST_CALC = 1'b1
   } cit_state_t;
endpackage : cit_pkg

// [hdl/cit_addsub.sv]
// Purpose: 8-bit add/subtract with carry, half carry and overflow
// Assumes: i_sub selects subtract-with-borrow, i_cin is carry or borrow in
// Notes: purely combinational
`timescale 1ns/100ps
`default_nettype none
module cit_addsub
   import cit_pkg::*;
(
   input  wire logic       i_sub,
   input  wire logic       i_cin,
   input  wire logic [7:0] i_a,
   input  wire logic [7:0] i_b,
   output logic     [7:0]  o_res,
   output logic            o_carry,
   output logic            o_half,
   output logic            o_ovf
);
   logic [4:0] lo;
   logic [8:0] full;

   // borrow out is bit 8 of the direct nine-bit difference
   always_comb
   begin
      if (i_sub)
      begin
         lo   = {1'b0, i_a[3:0]} - {1'b0, i_b[3:0]} - {4'h0, i_cin};
         full = {1'b0, i_a} - {1'b0, i_b} - {8'h00, i_cin};
      end
      else
      begin
         lo   = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, i_cin};
         full = {1'b0, i_a} + {1'b0, i_b} + {8'h00, i_cin};
      end
      o_res = full[7:0];
      o_carry = full[8];
      o_half  = lo[4];
      // signed overflow from operand and result signs
      o_ovf   = i_sub ? ((i_a[7] != i_b[7]) && (full[7] != i_a[7]))
                      : ((i_a[7] == i_b[7]) && (full[7] != i_a[7]));
   end
endmodule : cit_addsub
`default_nettype wire

// [hdl/cit_core.sv]
// Purpose: instruction sequencer with four-clock machine cycles and flag update
// Assumes: program memory presents the requested byte by the fourth clock
// Notes: register bank R0..R7 also backs direct, indirect and bit operands
`timescale 1ns/100ps
`default_nettype none
module cit_core
   import cit_pkg::*;
(
   input  wire logic        i_clk_sys,
   input  wire logic        i_rstn,
   input  wire logic [7:0]  i_code_byte,
   output logic             o_fetch_req,
   output logic     [15:0]  o_fetch_addr,
   output logic             o_mcycle_start,
   output logic             o_insn_done,
   output logic     [7:0]   o_acc,
   output logic     [7:0]   o_b,
   output logic             o_carry_flag,
   output logic             o_overflow_flag,
   output logic             o_half_carry_flag
);
   logic [1:0]  phase_q;
   logic [2:0]  mc_q;
   logic [2:0]  fc_q;
   cit_state_t  st_q;
   logic [15:0] pc_q;
   logic [7:0]  op_q, b1_q, b2_q;
   logic [7:0]  acc_q, b_q;
   logic        carry_q, ovf_q, half_q;
   logic [7:0]  rf_q [8];
   logic        ph_last, fetch_w, last_w;
   logic [7:0]  op_w, b1_w, b2_w, src_w, add_res, cmp_a, cmp_b;
   logic [2:0]  nbytes_w, ncyc_w;
   logic        sum_carry, sum_half, sum_ovf, bit_w, is_jmp, cmp_ne;
   logic [15:0] prod_w;
   logic [8:0]  bcd_w;

   // bytes and machine cycles per opcode
   function automatic logic [5:0] op_len(input logic [7:0] op);
      logic [2:0] nb;
      logic [2:0] nc;
      nb = CYC_SHORT;
      nc = CYC_SHORT;
      if (op[4:0] == LO_ABS_JUMP || op[4:0] == LO_ABS_CALL)
      begin
         nb = CYC_TWO;
         nc = CYC_THREE;  // RULE_04
      end
      else if (op[7:4] == HI_CMP_JUMP && op[3:2] != 2'h0)
      begin
         nb = CYC_THREE;
         nc = CYC_CMP_JUMP;  // RULE_08
      end
      else if (op == OP_MUL || op == OP_DIV)
         nc = CYC_MULDIV;
      else if (op == OP_ANLDI)
      begin
         nb = CYC_THREE;
         nc = CYC_THREE;
      end
      else if (op == OP_ANLC || op == OP_ANLCN || op == OP_ORLC || op == OP_ORLCN
               || op == OP_MOVC || op == OP_ANLDA
               || ((op[7:4] == HI_ADD || op[7:4] == HI_ADD_CARRY || op[7:4] == HI_SUB_BORROW
                    || op[7:4] == HI_ANL) && op[3:1] == 3'h2))
      begin
         nb = CYC_TWO;
         nc = CYC_TWO;  // RULE_08
      end
      return {nb, nc};
   endfunction : op_len

   // machine cycle phase: free running divide by four
   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
         phase_q <= PH_FETCH;
      else
         phase_q <= phase_q + 2'h1;  // RULE_01
   end

   assign ph_last        = (phase_q == PH_LAST);
   assign o_mcycle_start = (phase_q == PH_FETCH);
   // forward bytes arriving on the executing edge
   assign op_w   = (mc_q == 3'h0) ? i_code_byte : op_q;
   assign b1_w   = (mc_q == 3'h1 && st_q == ST_BYTE) ? i_code_byte : b1_q;
   assign b2_w   = (mc_q == 3'h2 && st_q == ST_BYTE) ? i_code_byte : b2_q;  // kept past fetch
   assign cmp_a  = (op_w[3:1] == 3'h2) ? acc_q : src_w;
   assign cmp_b  = (op_w[3:1] == 3'h2) ? src_w : b1_w;
   assign cmp_ne = (cmp_a != cmp_b);
   assign {nbytes_w, ncyc_w} = op_len(op_w);
   assign fetch_w      = (st_q == ST_BYTE);
   assign o_fetch_req  = o_mcycle_start && fetch_w;  // RULE_02
   assign o_fetch_addr = pc_q;
   assign last_w       = ph_last && (mc_q == ncyc_w - 3'h1);  // RULE_03
   assign o_insn_done  = last_w;
   assign is_jmp = (op_w[4:0] == LO_ABS_JUMP) || (op_w[4:0] == LO_ABS_CALL);

   // sequencing: byte cycles, then any extra cycles of jumps and mul/div
   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         mc_q <= 3'h0;
         fc_q <= 3'h0;
         st_q <= ST_BYTE;
         op_q <= BYTE_RESET;
         b1_q <= BYTE_RESET;
         b2_q <= BYTE_RESET;
      end
      else if (ph_last)
      begin
         case (st_q)
            ST_BYTE:
            begin
               if (mc_q == 3'h0)
                  op_q <= i_code_byte;
               if (mc_q == 3'h1)
                  b1_q <= i_code_byte;
               if (mc_q == 3'h2)
                  b2_q <= i_code_byte;
               // leave byte fetching once the last byte is in
               if (!last_w && fc_q + 3'h1 >= nbytes_w)
                  st_q <= ST_CALC;  // RULE_04
               fc_q <= fc_q + 3'h1;
            end
            ST_CALC: st_q <= ST_CALC;
            default: st_q <= ST_BYTE;
         endcase
         if (last_w)
         begin
            mc_q <= 3'h0;
            fc_q <= 3'h0;
            st_q <= ST_BYTE;
         end
         else
            mc_q <= mc_q + 3'h1;
      end
   end

   // source operand: Rn, @Ri, direct or immediate
   always_comb
   begin
      if (op_w[3])
         src_w = rf_q[op_w[2:0]];
      else if (op_w[3:1] == 3'h3)
         src_w = rf_q[rf_q[{2'h0, op_w[0]}][2:0]];
      else if (op_w[3:0] == 4'h5)
         src_w = rf_q[b1_w[2:0]];
      else
         src_w = b1_w;
   end

   assign bit_w  = rf_q[b1_w[5:3]][b1_w[2:0]];
   assign prod_w = acc_q * b_q;
   assign bcd_w  = ((acc_q[3:0] > BCD_MAX) || half_q) ? ({1'b0, acc_q} + {1'b0, BCD_LO_ADJ})
                                                      : {1'b0, acc_q};
   cit_addsub u_addsub (
      .i_sub   (op_w[7:4] == HI_SUB_BORROW),
      .i_cin   ((op_w[7:4] != HI_ADD) && carry_q),
      .i_a     (acc_q),
      .i_b     (src_w),
      .o_res   (add_res),
      .o_carry (sum_carry),
      .o_half  (sum_half),
      .o_ovf   (sum_ovf)
   );
   // program counter: advance per fetched byte, load on taken jumps
   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
         pc_q <= PC_RESET;
      else if (last_w && is_jmp)
         pc_q <= {pc_q[15:11], op_w[7:5], b1_w};  // RULE_04
      else if (last_w && op_w[7:4] == HI_CMP_JUMP && op_w[3:2] != 2'h0 && cmp_ne)
         pc_q <= pc_q + {{8{b2_w[7]}}, b2_w};  // RULE_05
      else if (ph_last && fetch_w)
         pc_q <= pc_q + 16'h0001;
   end

   // execution: accumulator, B, bank and flags at the last edge
   always_ff @(posedge i_clk_sys or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         acc_q <= BYTE_RESET;
         b_q   <= BYTE_RESET;
         carry_q <= 1'b0;
         ovf_q   <= 1'b0;
         half_q  <= 1'b0;
         for (int i = 0; i < 8; i++)
            rf_q[i] <= BYTE_RESET;
      end
      else if (last_w)
      begin
         if ((op_w[7:4] == HI_ADD || op_w[7:4] == HI_ADD_CARRY || op_w[7:4] == HI_SUB_BORROW)
             && op_w[3:2] != 2'h0)
         begin
            acc_q   <= add_res;    // RULE_05
            carry_q <= sum_carry;  // RULE_06
            half_q  <= sum_half;
            ovf_q   <= sum_ovf;
         end
         else if (op_w[7:4] == HI_ANL && op_w[3:2] != 2'h0)
            acc_q <= acc_q & src_w;
         else if (op_w[7:4] == HI_CMP_JUMP && op_w[3:2] != 2'h0)
         begin
            // borrow of first compare operand minus second
            carry_q <= (cmp_a < cmp_b);  // RULE_07
         end
         else if (op_w[3:0] == 4'h8 && op_w[7:4] == 4'h1)
            rf_q[op_w[2:0]] <= rf_q[op_w[2:0]] - 8'h01;
         else
         begin
            case (op_w)
               OP_MUL:
               begin
                  {b_q, acc_q} <= prod_w;
                  carry_q <= 1'b0;  // RULE_06
                  ovf_q   <= (prod_w[15:8] != 8'h00);
               end
               OP_DIV:
               begin
                  if (b_q != 8'h00)  // divide by zero leaves A and B untouched
                  begin
                     acc_q <= acc_q / b_q;
                     b_q   <= acc_q % b_q;
                  end
                  carry_q <= 1'b0;  // RULE_06
                  ovf_q   <= (b_q == 8'h00);
               end
               OP_DEC_ADJ:
               begin
                  if ((bcd_w[7:4] > BCD_MAX) || carry_q || bcd_w[8])
                  begin
                     acc_q   <= 8'(bcd_w + BCD_HI_ADJ);
                     carry_q <= 1'b1;  // RULE_07
                  end
                  else
                     acc_q <= bcd_w[7:0];
               end
               OP_RRC:  {acc_q, carry_q} <= {carry_q, acc_q};  // RULE_07
               OP_RLC:  {carry_q, acc_q} <= {acc_q, carry_q};  // RULE_07
               OP_SETC: carry_q <= 1'b1;  // RULE_06
               OP_CLRC: carry_q <= 1'b0;  // RULE_06
               OP_CPLC: carry_q <= !carry_q;  // RULE_07
               OP_ANLC: carry_q <= carry_q & bit_w;  // RULE_07
               OP_ANLCN: carry_q <= carry_q & !bit_w;
               OP_ORLC: carry_q <= carry_q | bit_w;
               OP_ORLCN: carry_q <= carry_q | !bit_w;
               OP_MOVC: carry_q <= bit_w;
               OP_ANLDA: rf_q[b1_w[2:0]] <= rf_q[b1_w[2:0]] & acc_q;
               OP_ANLDI: rf_q[b1_w[2:0]] <= rf_q[b1_w[2:0]] & b2_w;
               OP_CLRA: acc_q <= 8'h00;
               OP_CPLA: acc_q <= ~acc_q;
               OP_DECA: acc_q <= acc_q - 8'h01;
               default: acc_q <= acc_q;
            endcase
         end
      end
   end
   assign o_acc             = acc_q;
   assign o_b               = b_q;
   assign o_carry_flag      = carry_q;
   assign o_overflow_flag   = ovf_q;
   assign o_half_carry_flag = half_q;

   // checks
   sequence quiet_three_s;
      !o_mcycle_start [*3];
   endsequence
   mcycle_four_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // RULE_01
      o_mcycle_start |=> quiet_three_s ##1 o_mcycle_start)
      else $error("machine cycle not four clocks");
   fetch_single_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // RULE_02
      o_fetch_req |=> !o_fetch_req [*3])
      else $error("more than one fetch in a machine cycle");
   done_edge_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // RULE_01
      o_insn_done |=> o_mcycle_start)
      else $error("instruction not ending on a cycle boundary");
   byte_cycles_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // RULE_03
      (o_insn_done && !is_jmp && ncyc_w == nbytes_w && op_w != OP_MUL && op_w != OP_DIV)
      |-> (mc_q == fc_q))
      else $error("cycles differ from fetched bytes");
   jump_extra_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // RULE_04
      (o_insn_done && is_jmp) |-> (mc_q == 3'h2 && fc_q == 3'h2))
      else $error("jump lacks its address cycle");
   compare_jump_not_equal_op_cycles_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // RULE_08
      (o_insn_done && op_w[7:4] == HI_CMP_JUMP && op_w[3:2] != 2'h0) |-> (mc_q == 3'h3))
      else $error("compare jump not four cycles");
   carry_force_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // RULE_06
      (o_insn_done && (op_w == OP_SETC || op_w == OP_MUL))
      |=> (o_carry_flag == $past(op_w == OP_SETC)))
      else $error("forced carry wrong");
   carry_only_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // RULE_07
      (o_insn_done && (op_w == OP_CPLC || op_w == OP_RLC || op_w == OP_DEC_ADJ))
      |=> $stable(o_overflow_flag) && $stable(o_half_carry_flag))
      else $error("carry operation touched other flags");
   cpl_carry_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // RULE_05
      (o_insn_done && op_w == OP_CPLC) |=> (o_carry_flag != $past(o_carry_flag)))
      else $error("complement carry wrong");
endmodule : cit_core
`default_nettype wire

// [tb/cit_prog_mem.sv]
// Purpose: program memory model answering the sequencer's byte fetches
// Assumes: one fetch request per machine cycle, byte wanted by phase 3
// Notes: answers as late as allowed; the bus shows churn outside that slot
`timescale 1ns/100ps
`default_nettype none
module cit_prog_mem
(
   input  wire logic        i_clk_sys,
   input  wire logic        i_fetch_req,
   input  wire logic [15:0] i_fetch_addr,
   output logic      [7:0]  o_code_byte
);
   logic [7:0]  mem [256];
   logic [15:0] addr_q;
   logic [1:0]  cnt_q;

   // empty memory reads as no-op opcodes
   initial
   begin
      foreach (mem[i]) mem[i] = 8'h00;
      o_code_byte = 8'h5a;
      addr_q      = 16'h0000;
      cnt_q       = 2'h0;
   end

   // byte valid from the third clock's falling edge through the last clock, inverted noise elsewhere so a
   // design sampling early sees garbage rather than a lucky old value
   always @(negedge i_clk_sys)
   begin
      if (i_fetch_req === 1'b1)
      begin
         addr_q      <= i_fetch_addr;
         cnt_q       <= 2'h1;
         o_code_byte <= ~o_code_byte;
      end
      else if (cnt_q == 2'h1)
      begin
         cnt_q       <= 2'h2;
         o_code_byte <= ~o_code_byte;
      end
      else if (cnt_q == 2'h2)
      begin
         cnt_q       <= 2'h3;
         o_code_byte <= mem[addr_q[7:0]];
      end
      else if (cnt_q == 2'h3)
         cnt_q <= 2'h0;
      else
         o_code_byte <= ~o_code_byte;
   end
endmodule : cit_prog_mem
`default_nettype wire

// [tb/test_cpu_instruction_timing.sv]
// Purpose: self-checking bench for the four-clock instruction sequencer
// Assumes: inputs change at the falling edge, results one clock after done
// Notes: a short program walks arithmetic, carry ops, mul/div and jumps
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) \
   begin \
      comparisons++; \
      if ((a) !== (e)) \
      begin \
         n_mismatch++; \
         $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); \
      end \
   end
module test_cpu_instruction_timing;
   import cit_pkg::*;
   logic        i_clk_sys;
   logic        i_rstn;
   logic [7:0]  i_code_byte;
   logic        o_fetch_req;
   logic [15:0] o_fetch_addr;
   logic        o_mcycle_start;
   logic        o_insn_done;
   logic [7:0]  o_acc;
   logic [7:0]  o_b;
   logic        o_carry_flag;
   logic        o_overflow_flag;
   logic        o_half_carry_flag;
   int          n_mismatch  = 0;
   int          comparisons = 0;
   int          cycles      = 0;
   int          skew        = 1;

   cit_core DUT (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_code_byte(i_code_byte),
      .o_fetch_req(o_fetch_req), .o_fetch_addr(o_fetch_addr),
      .o_mcycle_start(o_mcycle_start), .o_insn_done(o_insn_done), .o_acc(o_acc),
      .o_b(o_b), .o_carry_flag(o_carry_flag), .o_overflow_flag(o_overflow_flag),
      .o_half_carry_flag(o_half_carry_flag));

   cit_prog_mem prog (.i_clk_sys(i_clk_sys), .i_fetch_req(o_fetch_req),
      .i_fetch_addr(o_fetch_addr), .o_code_byte(i_code_byte));

   // 50 MHz core clock
   initial i_clk_sys = 1'b0;
   always #10 i_clk_sys = ~i_clk_sys;

   // hang guard, the whole program needs well under a few hundred clocks
   always @(posedge i_clk_sys)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         n_mismatch++;
         test_done();
      end
   end

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : test_done

   // reset held three clocks, outputs checked while it is held
   task automatic do_reset();
      @(negedge i_clk_sys);
      i_rstn = 1'b0;
      repeat (3) @(negedge i_clk_sys);
      `CHK(o_fetch_addr, PC_RESET)
      `CHK({o_fetch_req, o_mcycle_start, o_insn_done}, 3'b110)
      `CHK({o_acc, o_carry_flag, o_overflow_flag, o_half_carry_flag}, 11'h000)
      i_rstn = 1'b1;
      skew   = 1;
      $display("test reset done");
   endtask : do_reset

   // one instruction: clocks, machine-cycle starts, fetches, then results
   task automatic step(input int mc, input int nbytes, input logic [7:0] acc,
                       input logic [2:0] fl, input logic [15:0] pc);
      int n;
      int nf;
      int ns;
      n    = skew;
      nf   = skew;
      ns   = skew;
      skew = 0;
      while (n < 40)
      begin
         @(negedge i_clk_sys);
         n++;
         if (o_fetch_req === 1'b1) nf++;
         if (o_mcycle_start === 1'b1) ns++;
         if (o_insn_done === 1'b1) break;
      end
      `CHK(n, 4 * mc)
      `CHK(ns, mc)
      `CHK(nf, nbytes)
      @(posedge i_clk_sys);
      #1;
      `CHK(o_acc, acc)
      `CHK({o_carry_flag, o_overflow_flag, o_half_carry_flag}, fl)
      `CHK(o_fetch_addr, pc)
      `CHK(o_fetch_req, 1'b1)
   endtask : step

   // flags as {carry, overflow, half carry}
   task automatic test_arith();
      step(1, 1, 8'h00, 3'b000, 16'h0001);
      step(2, 2, 8'h7f, 3'b000, 16'h0003);
      step(2, 2, 8'h80, 3'b011, 16'h0005);
      step(2, 2, 8'h00, 3'b110, 16'h0007);
      step(2, 2, 8'hfe, 3'b101, 16'h0009);
      $display("test arith done");
   endtask : test_arith

   task automatic test_carry();
      step(1, 1, 8'hfe, 3'b101, 16'h000a);
      step(1, 1, 8'hfe, 3'b001, 16'h000b);
      step(1, 1, 8'hfe, 3'b101, 16'h000c);
      step(1, 1, 8'hff, 3'b001, 16'h000d);
      step(1, 1, 8'hfe, 3'b101, 16'h000e);
      $display("test carry done");
   endtask : test_carry

   // b is zero: product zero, divide flags overflow and leaves a alone
   task automatic test_muldiv();
      step(5, 1, 8'h00, 3'b001, 16'h000f);
      step(5, 1, 8'h00, 3'b011, 16'h0010);
      `CHK(o_b, 8'h00)
      $display("test muldiv done");
   endtask : test_muldiv

   // extra address cycle on jumps, compare sets carry from a < data
   task automatic test_jumps();
      step(3, 2, 8'h00, 3'b011, 16'h0020);
      step(4, 3, 8'h00, 3'b111, 16'h0026);
      step(1, 1, 8'h66, 3'b111, 16'h0027);
      step(3, 2, 8'h66, 3'b111, 16'h0030);
      $display("test jumps done");
   endtask : test_jumps

   // a reset in mid-run restarts at address zero with cleared state
   task automatic test_rerun();
      repeat (5) @(negedge i_clk_sys);
      do_reset();
      step(1, 1, 8'h00, 3'b000, 16'h0001);
      $display("test rerun done");
   endtask : test_rerun

   initial
   begin
      logic [7:0] lo [18];
      logic [7:0] hi [7];
      lo = '{8'he4, 8'h24, 8'h7f, 8'h24, 8'h01, 8'h34, 8'h80, 8'h94, 8'h01,
             8'hd3, 8'hc3, 8'hb3, 8'h13, 8'h33, 8'ha4, 8'h84, 8'h01, 8'h20};
      hi = '{8'hb4, 8'h05, 8'h03, 8'h00, 8'h00, 8'h00, 8'hd4};
      i_rstn = 1'b0;
      foreach (lo[i]) prog.mem[i] = lo[i];
      foreach (hi[i]) prog.mem[8'h20 + i] = hi[i];
      prog.mem[8'h27] = 8'h11;
      prog.mem[8'h28] = 8'h30;
      do_reset();
      test_arith();
      test_carry();
      test_muldiv();
      test_jumps();
      test_rerun();
      test_done();
   end
endmodule : test_cpu_instruction_timing
`default_nettype wire
